/* File: motion_activity_detector.v */
// activity detector for a three-axis acceleration sensor, with apb registers
`timescale 1ns/1ps
`include "motion_activity_detector_regs.vh"

module motion_activity_detector #(
  parameter TICK_CYCLES = `ACT_TICK_CYCLES          // cycles per duration count
) (
  input  wire        I_CLK,                         // 40 mhz clock
  input  wire        I_RST_N,                       // synchronous reset, active low
  input  wire [11:0] I_PADDR,                       // apb byte address
  input  wire        I_PSEL,                        // apb select
  input  wire        I_PENABLE,                     // apb access phase
  input  wire        I_PWRITE,                      // apb write
  input  wire [31:0] I_PWDATA,                      // apb write data
  input  wire        I_SAMPLE_VALID,                // one-cycle strobe, new sample set
  input  wire [11:0] I_SAMPLE_X,                    // signed low-resolution x sample
  input  wire [11:0] I_SAMPLE_Y,                    // signed low-resolution y sample
  input  wire [11:0] I_SAMPLE_Z,                    // signed low-resolution z sample
  output reg  [31:0] O_PRDATA,                      // apb read data
  output reg         O_PREADY,                      // apb ready
  output reg         O_PSLVERR,                     // apb error, unmapped address
  output reg         O_ACT_EVENT,                   // one-cycle pulse per activity event
  output reg         O_IRQ                          // level interrupt
);

  // wrap value of the tick counter; the default count fits sixteen bits
  // a longer tick would need a wider counter, so the cut here is deliberate
  localparam [31:0] TICK_LAST_FULL = TICK_CYCLES - 1;
  localparam [15:0] TICK_LAST      = TICK_LAST_FULL[15:0]; // tick counter wrap value

  // scaled magnitude of a signed 13-bit difference; 17 bits hold 4096*16
  // the most negative difference still fits, as the magnitude is unsigned
  function [16:0] scaled_mag;
    input [12:0] diff;
    reg   [12:0] mag;
    begin
      mag = diff[12] ? (~diff + 13'h0001) : diff;
      scaled_mag = {mag, 4'h0};                     // shift left by four
    end
  endfunction

  // sign-extended difference of sample and reference
  // one extra bit keeps the subtraction from wrapping at full scale
  function [12:0] axis_diff;
    input [11:0] sample;
    input [11:0] ref_val;
    begin
      axis_diff = {sample[11], sample} - {ref_val[11], ref_val};
    end
  endfunction

  // byte address to register index, with alignment check
  // a misaligned address sets the top bit, so it never matches a register
  function [8:0] addr_index;
    input [11:0] addr;
    begin
      addr_index = {(addr[1:0] != 2'b00), addr[9:2]};
    end
  endfunction

  // ---------------------------------------------------------------
  // software-visible configuration
  reg  [1:0]  enable_reg;
  reg  [2:0]  axis_reg;
  reg  [10:0] thresh_reg;
  reg  [23:0] duration_reg;

  // event flag and its interrupt mask
  reg         status_reg;
  reg         int_en_reg;

  // baseline captured for referenced mode
  reg  [11:0] ref_x_reg;
  reg  [11:0] ref_y_reg;
  reg  [11:0] ref_z_reg;
  reg         ref_valid_reg;

  // duration timing: ticks inside one count, and completed counts
  reg         above_reg;
  reg  [15:0] tick_reg;
  reg  [23:0] count_reg;

  wire        access = I_PSEL & I_PENABLE;
  wire        wr_do  = access & O_PREADY & I_PWRITE;
  wire [8:0]  idx    = addr_index(I_PADDR);
  wire        hi_ok  = (I_PADDR[11:10] == 2'b00);

  // unmapped index decode shared by read and error paths
  // reserved bits and the write-only clear register read as zero
  reg         mapped;
  reg  [31:0] rd_word;
  always @* begin
    mapped  = hi_ok;
    rd_word = 32'h00000000;
    if (idx == {1'b0, `IDX_ACT_CTRL}) begin
      rd_word[1:0] = enable_reg;
    end else if (idx == {1'b0, `IDX_AXIS_SEL}) begin
      rd_word[2:0] = axis_reg;
    end else if (idx == {1'b0, `IDX_THRESH_HIGH}) begin
      rd_word[2:0] = thresh_reg[10:8];              // bits 7:3 read zero
    end else if (idx == {1'b0, `IDX_THRESH_LOW}) begin
      rd_word[7:0] = thresh_reg[7:0];
    end else if (idx == {1'b0, `IDX_DUR_HIGH}) begin
      rd_word[7:0] = duration_reg[23:16];
    end else if (idx == {1'b0, `IDX_DUR_MID}) begin
      rd_word[7:0] = duration_reg[15:8];
    end else if (idx == {1'b0, `IDX_DUR_LOW}) begin
      rd_word[7:0] = duration_reg[7:0];
    end else if (idx == {1'b0, `IDX_INT_STATUS}) begin
      rd_word[`INT_ACT_BIT] = status_reg;
    end else if (idx == {1'b0, `IDX_INT_ENABLE}) begin
      rd_word[`INT_ACT_BIT] = int_en_reg;
    end else if (idx == {1'b0, `IDX_INT_CLEAR}) begin
      rd_word = 32'h00000000;                       // write-only, reads zero
    end else if (idx == {1'b0, `IDX_LIVE_STATE}) begin
      rd_word[0] = above_reg;
      rd_word[1] = ref_valid_reg;
    end else begin
      mapped = 1'b0;
    end
  end

  // a write lands only at the completing edge of a mapped transfer
  wire        wr_ok  = wr_do & mapped & ~O_PSLVERR;

  // apb answer: one wait cycle, then ready with registered data
  // the wait cycle lets read data come from a flip-flop, at the cost of
  // one extra cycle on every transfer
  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_PREADY  <= 1'b0;
      O_PRDATA  <= 32'h00000000;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY  <= access & ~O_PREADY;
      O_PSLVERR <= access & ~O_PREADY & ~mapped;
      if (access & ~O_PREADY & ~I_PWRITE & mapped) begin
        O_PRDATA <= rd_word;
      end else begin
        O_PRDATA <= 32'h00000000;
      end
    end
  end

  // configuration writes take effect at the completing edge only
  // multi-byte values change a byte at a time, so software should
  // disable the detector while it rewrites the threshold or duration
  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      enable_reg   <= `RST_ENABLE;
      axis_reg     <= `RST_AXIS;
      thresh_reg   <= `RST_THRESH;
      duration_reg <= `RST_DURATION;
      int_en_reg   <= 1'b0;
    end else if (wr_ok) begin
      if (idx == {1'b0, `IDX_ACT_CTRL}) begin
        enable_reg <= I_PWDATA[1:0];
      end else if (idx == {1'b0, `IDX_AXIS_SEL}) begin
        axis_reg <= I_PWDATA[2:0];
      end else if (idx == {1'b0, `IDX_THRESH_HIGH}) begin
        thresh_reg[10:8] <= I_PWDATA[2:0];          // upper bits dropped
      end else if (idx == {1'b0, `IDX_THRESH_LOW}) begin
        thresh_reg[7:0] <= I_PWDATA[7:0];
      end else if (idx == {1'b0, `IDX_DUR_HIGH}) begin
        duration_reg[23:16] <= I_PWDATA[7:0];
      end else if (idx == {1'b0, `IDX_DUR_MID}) begin
        duration_reg[15:8] <= I_PWDATA[7:0];
      end else if (idx == {1'b0, `IDX_DUR_LOW}) begin
        duration_reg[7:0] <= I_PWDATA[7:0];
      end else if (idx == {1'b0, `IDX_INT_ENABLE}) begin
        int_en_reg <= I_PWDATA[`INT_ACT_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // detector mode decode
  // codes 00 and 10 both leave the detector idle
  wire det_on  = (enable_reg == `ACT_MODE_ABSOLUTE) |
                 (enable_reg == `ACT_MODE_REFERENCED);
  wire det_ref = (enable_reg == `ACT_MODE_REFERENCED);

  // absolute mode compares against zero; referenced against captured sample
  // the baseline is held until the next event
  wire [11:0] use_rx = det_ref ? ref_x_reg : 12'h000;
  wire [11:0] use_ry = det_ref ? ref_y_reg : 12'h000;
  wire [11:0] use_rz = det_ref ? ref_z_reg : 12'h000;

  // per-axis scaled distance from the baseline; 17 bits cover a full swing
  wire [16:0] mag_x = scaled_mag(axis_diff(I_SAMPLE_X, use_rx));
  wire [16:0] mag_y = scaled_mag(axis_diff(I_SAMPLE_Y, use_ry));
  wire [16:0] mag_z = scaled_mag(axis_diff(I_SAMPLE_Z, use_rz));

  // threshold is in raw codes, never rescaled by range
  wire [16:0] thr_ext = {6'h00, thresh_reg};
  wire exceed_x = axis_reg[0] & (mag_x > thr_ext);
  wire exceed_y = axis_reg[1] & (mag_y > thr_ext);
  wire exceed_z = axis_reg[2] & (mag_z > thr_ext);
  wire exceed   = exceed_x | exceed_y | exceed_z;

  // referenced mode needs a captured baseline before it may compare
  // samples in an idle mode are dropped without effect
  wire sample_ok = I_SAMPLE_VALID & det_on & (~det_ref | ref_valid_reg);

  // detection waits while the last event is still unacknowledged
  // only a clear re-arms the detector, in either mode
  wire armed     = ~status_reg;
  wire tick_wrap = (tick_reg == TICK_LAST);
  wire zero_dur  = (duration_reg == 24'h000000);

  // last tick of the last count, and a quiet sample arriving now
  wire dur_done  = tick_wrap & (count_reg + 24'h000001 == duration_reg);
  wire dip_now   = sample_ok & ~exceed;

  // event: first exceeding sample with zero duration, else end of duration
  // a quiet sample in the closing cycle still cancels the event
  wire fire_zero = sample_ok & exceed & zero_dur;
  wire fire_dur  = above_reg & ~zero_dur & dur_done & ~dip_now;
  wire fire      = armed & det_on & (fire_zero | fire_dur);

  // above-threshold tracking and duration timing
  // the timer runs only while an exceedance lasts; any dip starts it over
  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      above_reg <= 1'b0;
      tick_reg  <= 16'h0000;
      count_reg <= 24'h000000;
    end else if (~det_on | ~armed | fire) begin
      above_reg <= 1'b0;                            // disabled block is held idle
      tick_reg  <= 16'h0000;
      count_reg <= 24'h000000;
    end else if (dip_now) begin
      above_reg <= 1'b0;                            // any dip restarts the duration
      tick_reg  <= 16'h0000;
      count_reg <= 24'h000000;
    end else if (sample_ok & exceed & ~above_reg) begin
      above_reg <= 1'b1;                            // timing starts at first exceeding sample
      tick_reg  <= 16'h0000;
      count_reg <= 24'h000000;
    end else if (above_reg) begin
      if (tick_wrap) begin
        tick_reg  <= 16'h0000;
        count_reg <= count_reg + 24'h000001;        // one count per 500 us
      end else begin
        tick_reg <= tick_reg + 16'h0001;
      end
    end
  end

  // reference capture: first sample after enabling, then after each event
  // the capturing sample is never compared, so it can raise no event
  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      ref_valid_reg <= 1'b0;
      ref_x_reg     <= 12'h000;
      ref_y_reg     <= 12'h000;
      ref_z_reg     <= 12'h000;
    end else if (~det_ref | fire) begin
      ref_valid_reg <= 1'b0;
    end else if (I_SAMPLE_VALID & ~ref_valid_reg) begin
      ref_valid_reg <= 1'b1;
      ref_x_reg     <= I_SAMPLE_X;
      ref_y_reg     <= I_SAMPLE_Y;
      ref_z_reg     <= I_SAMPLE_Z;
    end
  end

  // sticky status; a new event in the clearing cycle wins over the clear
  wire clr_hit = wr_ok & (idx == {1'b0, `IDX_INT_CLEAR}) &
                 I_PWDATA[`INT_ACT_BIT];
  wire status_next = fire | (status_reg & ~clr_hit);

  // mask value after this edge, so the interrupt follows a mask write at once
  wire en_hit      = wr_ok & (idx == {1'b0, `IDX_INT_ENABLE});
  wire int_en_next = en_hit ? I_PWDATA[`INT_ACT_BIT] : int_en_reg;

  // status, event pulse and interrupt all come straight from flip-flops
  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      status_reg  <= 1'b0;
      O_ACT_EVENT <= 1'b0;
      O_IRQ       <= 1'b0;
    end else begin
      status_reg  <= status_next;
      O_ACT_EVENT <= fire;
      O_IRQ       <= status_next & int_en_next;
    end
  end

endmodule

/* File: motion_activity_detector_regs.vh */
// register map, field layout and timing constants of the activity detector
`ifndef MOTION_ACTIVITY_DETECTOR_REGS_VH
`define MOTION_ACTIVITY_DETECTOR_REGS_VH

// register indices; byte address on the bus is four times the index
`define IDX_ACT_CTRL        8'h37
`define IDX_AXIS_SEL        8'h38
`define IDX_THRESH_HIGH     8'h39
`define IDX_THRESH_LOW      8'h3a
`define IDX_DUR_HIGH        8'h3b
`define IDX_DUR_MID         8'h3c
`define IDX_DUR_LOW         8'h3d
`define IDX_INT_STATUS      8'h44
`define IDX_INT_ENABLE      8'h45
`define IDX_INT_CLEAR       8'h46
`define IDX_LIVE_STATE      8'h47

// reset values
`define RST_BYTE            8'h00
`define RST_ENABLE          2'b00
`define RST_AXIS            3'b000
`define RST_THRESH          11'h000
`define RST_DURATION        24'h000000

// field positions
`define THRESH_HIGH_MSB     2
`define THRESH_HIGH_WIDTH   3
`define AXIS_SEL_WIDTH      3
`define ENABLE_WIDTH        2
`define INT_ACT_BIT         0

// activity enable field encodings
`define ACT_MODE_ABSOLUTE   2'b01
`define ACT_MODE_REFERENCED 2'b11

// sample scaling: samples are multiplied by 16 before compare
`define SAMPLE_SHIFT        4

// timing: one duration count is 500 us; clock period 25 ns
`define ACT_TICK_NS         500000
`define CLK_PERIOD_NS       25
`define ACT_TICK_CYCLES     ((`ACT_TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: motion_activity_detector_assertions.sv */
// port-level assertions for the activity detector
`timescale 1ns/1ps
module motion_activity_detector_assertions #(
  parameter TICK_CYCLES = 4
) (
  input wire        I_CLK,
  input wire        I_RST_N,
  input wire [11:0] I_PADDR,
  input wire        I_PSEL,
  input wire        I_PENABLE,
  input wire        I_PWRITE,
  input wire [31:0] I_PWDATA,
  input wire        I_SAMPLE_VALID,
  input wire [11:0] I_SAMPLE_X,
  input wire [11:0] I_SAMPLE_Y,
  input wire [11:0] I_SAMPLE_Z,
  input wire [31:0] O_PRDATA,
  input wire        O_PREADY,
  input wire        O_PSLVERR,
  input wire        O_ACT_EVENT,
  input wire        O_IRQ
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  // access phase still waiting, and a completed write
  wire wait_c = I_PSEL && I_PENABLE && !O_PREADY;
  wire wr_c   = O_PREADY && I_PWRITE;
  property p_one_wait; wait_c |=> O_PREADY; endproperty
  a_one_wait: assert property (p_one_wait) else $error("ready missing");
  property p_ready_pulse; O_PREADY |=> !O_PREADY; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  property p_err_low; wait_c && I_PADDR < 12'h0dc |=> O_PSLVERR; endproperty
  a_err_low: assert property (p_err_low) else $error("unmapped not refused");
  property p_ok_map;
    wait_c && I_PADDR[1:0] == 2'b00 && I_PADDR >= 12'h0e4 && I_PADDR <= 12'h0f4
      |=> !O_PSLVERR;
  endproperty
  a_ok_map: assert property (p_ok_map) else $error("mapped refused");
  property p_rd_idle; !O_PREADY |-> O_PRDATA == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
  property p_upper; O_PREADY |-> O_PRDATA[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_thr_ro; O_PREADY && !I_PWRITE && I_PADDR == 12'h0e4 |-> O_PRDATA[7:3] == 5'h0;
  endproperty
  a_thr_ro: assert property (p_thr_ro) else $error("threshold high spare bits");
  property p_ev_pulse; O_ACT_EVENT |=> !O_ACT_EVENT; endproperty
  a_ev_pulse: assert property (p_ev_pulse) else $error("event too long");
  property p_irq_fall; $fell(O_IRQ) |-> $past(wr_c) || $past(wr_c, 2) || $past(wr_c, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped alone");
  property p_err_ready; O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h0; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error outside answer");
  property p_irq_rise; $rose(O_IRQ) |-> O_ACT_EVENT || $past(wr_c); endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt raised alone");
  c_event: cover property (O_ACT_EVENT);
  c_irq: cover property ($fell(O_IRQ));
  c_err: cover property (O_PSLVERR);
endmodule
bind motion_activity_detector motion_activity_detector_assertions #(
  .TICK_CYCLES(TICK_CYCLES)) i_chk (
  .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_PADDR(I_PADDR), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PWDATA(I_PWDATA),
  .I_SAMPLE_VALID(I_SAMPLE_VALID), .I_SAMPLE_X(I_SAMPLE_X), .I_SAMPLE_Y(I_SAMPLE_Y),
  .I_SAMPLE_Z(I_SAMPLE_Z), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .O_ACT_EVENT(O_ACT_EVENT), .O_IRQ(O_IRQ));

/* File: tb_motion_activity_detector.sv */
// self-checking bench for the activity detector
`timescale 1ns/1ps
`include "motion_activity_detector_regs.vh"
module tb_motion_activity_detector;
  localparam TICK = 4;
  logic        I_CLK, I_RST_N, I_PSEL, I_PENABLE, I_PWRITE, I_SAMPLE_VALID;
  logic [11:0] I_PADDR, I_SAMPLE_X, I_SAMPLE_Y, I_SAMPLE_Z, x, y, z;
  logic [31:0] I_PWDATA, rd;
  wire  [31:0] O_PRDATA;
  wire         O_PREADY, O_PSLVERR, O_ACT_EVENT, O_IRQ;
  logic [10:0] thr;
  logic [7:0]  ix;
  logic [2:0]  ax;
  logic [1:0]  md;
  logic        err;
  int          errors, compares, n;
  motion_activity_detector #(.TICK_CYCLES(TICK)) i_dut (
    .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_PADDR(I_PADDR), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PWDATA(I_PWDATA),
    .I_SAMPLE_VALID(I_SAMPLE_VALID), .I_SAMPLE_X(I_SAMPLE_X), .I_SAMPLE_Y(I_SAMPLE_Y),
    .I_SAMPLE_Z(I_SAMPLE_Z), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR), .O_ACT_EVENT(O_ACT_EVENT), .O_IRQ(O_IRQ));
  // 40 mhz clock
  initial begin
    I_CLK = 1'b0;
    forever #12.5 I_CLK = ~I_CLK;
  end
  task close_out;
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; waits for ready with no assumed latency
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge I_CLK);
    I_PSEL <= 1'b1;
    I_PWRITE <= w;
    I_PADDR <= {2'b00, idx, 2'b00};
    I_PWDATA <= wd;
    @(posedge I_CLK);
    I_PENABLE <= 1'b1;
    do @(posedge I_CLK); while (O_PREADY !== 1'b1);
    rd = O_PRDATA;
    err = O_PSLVERR;
    I_PSEL <= 1'b0;
    I_PENABLE <= 1'b0;
  endtask
  task set_thr(input logic [10:0] t);
    apb(1'b1, `IDX_THRESH_HIGH, {29'h0, t[10:8]});
    apb(1'b1, `IDX_THRESH_LOW, {24'h0, t[7:0]});
  endtask
  // one sample set; the event of a zero duration shows right after its edge
  task smp(input logic [11:0] sx, sy, sz, input logic ev);
    @(posedge I_CLK);
    I_SAMPLE_VALID <= 1'b1;
    I_SAMPLE_X <= sx;
    I_SAMPLE_Y <= sy;
    I_SAMPLE_Z <= sz;
    @(posedge I_CLK);
    I_SAMPLE_VALID <= 1'b0;
    #1 chk("event", O_ACT_EVENT, ev);
  endtask
  // scaled magnitude strictly above the raw-code threshold
  function automatic logic over(input logic [11:0] s, input logic [10:0] t);
    logic [11:0] m;
    m = s[11] ? -s : s;
    return {m, 4'h0} > {5'h00, t};
  endfunction
  // watchdog, far beyond the expected run
  initial begin
    #500000;
    errors++;
    close_out();
  end
  initial begin
    {I_RST_N, I_PSEL, I_PENABLE, I_PWRITE, I_SAMPLE_VALID} = 5'h00;
    {I_PADDR, I_PWDATA, I_SAMPLE_X, I_SAMPLE_Y, I_SAMPLE_Z} = 80'h0;
    void'($urandom(32'hc728));
    repeat (12) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    // reset values and access kinds of the five threshold and duration bytes
    for (int a = 0; a < 5; a++) begin
      ix = 8'(`IDX_THRESH_HIGH + a);
      apb(1'b0, ix, 32'h0);
      chk("reset", rd, 32'h0);
      apb(1'b1, ix, 32'hffffffff);
      apb(1'b0, ix, 32'h0);
      chk("readback", rd, a == 0 ? 32'h07 : 32'hff);
      apb(1'b1, ix, 32'h0);
    end
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped", err, 1'b1);
    apb(1'b1, `IDX_INT_ENABLE, 32'h1);
    // random modes, axes, thresholds and signed samples
    for (int i = 0; i < 120; i++) begin
      md = 2'($urandom_range(0, 2));
      ax = 3'($urandom);
      thr = 11'($urandom);
      x = 12'($urandom_range(0, 320)) - 12'h0a0;
      y = 12'($urandom_range(0, 320)) - 12'h0a0;
      z = 12'($urandom_range(0, 320)) - 12'h0a0;
      apb(1'b1, `IDX_ACT_CTRL, {30'h0, md});
      apb(1'b1, `IDX_AXIS_SEL, {29'h0, ax});
      set_thr(thr);
      smp(x, y, z, md == 2'b01 && |(ax & {over(z, thr), over(y, thr), over(x, thr)}));
      apb(1'b1, `IDX_INT_CLEAR, 32'h1);
    end
    // boundary: equal is not above, negative counts by magnitude
    apb(1'b1, `IDX_ACT_CTRL, 32'h1);
    apb(1'b1, `IDX_AXIS_SEL, 32'h1);
    set_thr(11'h020);
    smp(12'h002, 12'h0, 12'h0, 1'b0);
    smp(12'hffd, 12'h0, 12'h0, 1'b1);
    apb(1'b1, `IDX_INT_CLEAR, 32'h1);
    // referenced mode: first sample only sets the reference
    set_thr(11'h010);
    apb(1'b1, `IDX_ACT_CTRL, 32'h3);
    smp(12'h064, 12'h0, 12'h0, 1'b0);
    smp(12'h065, 12'h0, 12'h0, 1'b0);
    smp(12'h066, 12'h0, 12'h0, 1'b1);
    // sticky status, masking and clearing of the interrupt
    apb(1'b0, `IDX_INT_STATUS, 32'h0);
    chk("status", rd, 32'h1);
    chk("irq", O_IRQ, 1'b1);
    apb(1'b1, `IDX_INT_ENABLE, 32'h0);
    apb(1'b0, `IDX_INT_STATUS, 32'h0);
    chk("irq masked", O_IRQ, 1'b0);
    apb(1'b1, `IDX_INT_ENABLE, 32'h1);
    apb(1'b1, `IDX_INT_CLEAR, 32'h1);
    apb(1'b0, `IDX_INT_STATUS, 32'h0);
    chk("cleared", rd, 32'h0);
    chk("irq off", O_IRQ, 1'b0);
    // duration of two counts, then one broken by a quiet sample
    apb(1'b1, `IDX_ACT_CTRL, 32'h1);
    apb(1'b1, `IDX_DUR_LOW, 32'h2);
    smp(12'h003, 12'h0, 12'h0, 1'b0);
    n = 1;
    while (O_ACT_EVENT !== 1'b1 && n < 40) begin
      @(posedge I_CLK);
      #1 n++;
    end
    chk("delay", n, 2 * TICK + 1);
    apb(1'b1, `IDX_INT_CLEAR, 32'h1);
    smp(12'h003, 12'h0, 12'h0, 1'b0);
    repeat (4) @(posedge I_CLK);
    smp(12'h0, 12'h0, 12'h0, 1'b0);
    repeat (12) @(posedge I_CLK);
    apb(1'b0, `IDX_INT_STATUS, 32'h0);
    chk("broken", rd, 32'h0);
    close_out();
  end
endmodule
